/* aic_pkg.sv */
package aic_pkg;

  localparam int AIC_DATA_W = 4;
  localparam int AIC_ADDR_W = 5;
  localparam int AIC_EVT_N  = 3;

  localparam logic [4:0] OFF_INSTR    = 5'h00;
  localparam logic [4:0] OFF_ACC      = 5'h04;
  localparam logic [4:0] OFF_CARRY    = 5'h08;
  localparam logic [4:0] OFF_CTRL     = 5'h0c;
  localparam logic [4:0] OFF_STATUS   = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_CLR  = 5'h18;
  localparam logic [4:0] OFF_IRQ_EN   = 5'h1c;

  localparam int INSTR_OP_LSB  = 4;
  localparam int INSTR_IMM_LSB = 0;
  localparam int CTRL_COMP_BIT = 3;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam int EVT_DONE_BIT  = 0;
  localparam int EVT_SKIP_BIT  = 1;
  localparam int EVT_OVF_BIT   = 2;

  localparam logic [3:0] ACC_RST   = 4'h0;
  localparam logic [3:0] CTRL_RST  = 4'h0;
  localparam logic       CARRY_RST = 1'b0;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADD_IMM,
    OP_CONVERT_START,
    OP_SKIP_IF_DONE,
    OP_LOAD_IMM
  } aic_op_t;

endpackage

/* aic_add4.sv */
`timescale 1ns/1ps
module aic_add4
  import aic_pkg::*;
#(
  parameter int W = AIC_DATA_W
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  output logic      [W-1:0] sum,
  output logic              ovf
);

  logic [W:0] full;

  // Overflow is the carry out of the top bit
  always_comb begin
    full = {1'b0, a} + {1'b0, b};
    sum  = full[W-1:0];
    ovf  = full[W];
  end

endmodule // aic_add4

/* aic_irq.sv */
`timescale 1ns/1ps
module aic_irq
  import aic_pkg::*;
#(
  parameter int N = AIC_EVT_N
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [N-1:0] evt,
  input  wire logic         clrWe,
  input  wire logic [N-1:0] clrData,
  input  wire logic         enWe,
  input  wire logic [N-1:0] enData,
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);

  logic [N-1:0] next_status;
  logic [N-1:0] next_enable;
  logic         next_irq;

  // A new event wins over a clear in the same cycle
  always_comb begin
    next_status = status;
    next_enable = enable;
    if (clrWe) begin
      next_status = next_status & ~clrData;
    end
    next_status = next_status | evt;
    if (enWe) begin
      next_enable = enData;
    end
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
      enable <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      irq    <= next_irq;
    end
  end

endmodule // aic_irq

/* aic_exec.sv */
// Notes on behaviour
// - Add-immediate adds the immediate field to the accumulator, result kept.
// - Add-immediate leaves the carry flag unchanged.
// - Add-immediate overflow skips the next instruction; otherwise no skip.
// - Convert-start clears the conversion-done flag.
// - Convert-start with comparator select zero launches a conversion.
// - Convert-start with comparator select one launches a comparator run.
// - Comparator select is bit 3 of the converter control register.
// - Done test skips next when flag set, then clears the flag.
`timescale 1ns/1ps
module aic_exec
  import aic_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic [AIC_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  convDone,
  output logic                       convStart,
  output logic                       compStart,
  output logic                       irq
);

  logic [3:0]           acc;
  logic [3:0]           next_acc;
  logic                 carry;
  logic                 next_carry;
  logic [3:0]           ctrl;
  logic [3:0]           next_ctrl;
  logic                 doneFlag;
  logic                 next_doneFlag;
  logic                 skipPending;
  logic                 next_skipPending;
  logic [7:0]           lastInstr;
  logic [7:0]           next_lastInstr;
  logic                 next_convStart;
  logic                 next_compStart;
  logic                 next_waitrequest;
  logic [31:0]          next_readdata;
  logic                 wrEn;
  logic                 instrTake;
  logic                 doneClr;
  aic_op_t              op;
  logic [3:0]           imm;
  logic [3:0]           addSum;
  logic                 addOvf;
  logic                 execAdd;
  logic                 execStart;
  logic                 execTest;
  logic [AIC_EVT_N-1:0] evt;
  logic [AIC_EVT_N-1:0] irqStatus;
  logic [AIC_EVT_N-1:0] irqEnable;

  // One write strobe per register offset
  function automatic logic wr_hit(input logic                  we,
                                  input logic [AIC_ADDR_W-1:0] addr,
                                  input logic [AIC_ADDR_W-1:0] off);
    return we && (addr == off);
  endfunction

  // Bus decode and instruction fields
  always_comb begin
    wrEn = avs_write && !avs_waitrequest && avs_byteenable[0];
    instrTake = wr_hit(wrEn, avs_address, OFF_INSTR);
    op = aic_op_t'(avs_writedata[INSTR_OP_LSB +: 4]);
    imm = avs_writedata[INSTR_IMM_LSB +: 4];
    execAdd = instrTake && !skipPending && (op == OP_ADD_IMM);
    execStart = instrTake && !skipPending && (op == OP_CONVERT_START);
    execTest = instrTake && !skipPending && (op == OP_SKIP_IF_DONE);
  end

  aic_add4 #(
    .W (AIC_DATA_W)
  ) u_add (
    .a   (acc),
    .b   (imm),
    .sum (addSum),
    .ovf (addOvf)
  );

  // One wait state: the answer is registered on the same edge that drops waitrequest
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          OFF_INSTR:    next_readdata[7:0] = lastInstr;
          OFF_ACC:      next_readdata[3:0] = acc;
          OFF_CARRY:    next_readdata[0] = carry;
          OFF_CTRL:     next_readdata[3:0] = ctrl;
          OFF_STATUS: begin
            next_readdata[STAT_DONE_BIT] = doneFlag;
            next_readdata[STAT_SKIP_BIT] = skipPending;
          end
          OFF_IRQ_STAT: next_readdata[AIC_EVT_N-1:0] = irqStatus;
          OFF_IRQ_EN:   next_readdata[AIC_EVT_N-1:0] = irqEnable;
          default:      next_readdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Instruction execution
  always_comb begin
    next_acc = acc;
    next_carry = carry;
    next_ctrl = ctrl;
    next_skipPending = skipPending;
    next_lastInstr = lastInstr;
    next_convStart = 1'b0;
    next_compStart = 1'b0;
    doneClr = 1'b0;
    if (instrTake) begin
      next_lastInstr = avs_writedata[7:0];
      if (skipPending) begin
        next_skipPending = 1'b0;
      end else begin
        unique case (op)
          OP_ADD_IMM: begin
            next_acc = addSum;
            next_skipPending = addOvf;
          end
          OP_CONVERT_START: begin
            doneClr = 1'b1;
            if (ctrl[CTRL_COMP_BIT]) begin
              next_compStart = 1'b1;
            end else begin
              next_convStart = 1'b1;
            end
          end
          OP_SKIP_IF_DONE: begin
            if (doneFlag) begin
              next_skipPending = 1'b1;
              doneClr = 1'b1;
            end
          end
          OP_LOAD_IMM: next_acc = imm;
          OP_NOP:      next_acc = acc;
          default:     next_acc = acc;
        endcase
      end
    end
    // Carry is only written from the bus, never by add-immediate
    if (wr_hit(wrEn, avs_address, OFF_CARRY)) begin
      next_carry = avs_writedata[0];
    end
    if (wr_hit(wrEn, avs_address, OFF_ACC)) begin
      next_acc = avs_writedata[3:0];
    end
    if (wr_hit(wrEn, avs_address, OFF_CTRL)) begin
      next_ctrl = avs_writedata[3:0];
    end
    // Completion from the converter wins over a clear
    next_doneFlag = convDone ? 1'b1 : (doneClr ? 1'b0 : doneFlag);
    evt = '0;
    evt[EVT_DONE_BIT] = convDone;
    evt[EVT_SKIP_BIT] = instrTake && skipPending;
    evt[EVT_OVF_BIT] = execAdd && addOvf;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc             <= ACC_RST;
      carry           <= CARRY_RST;
      ctrl            <= CTRL_RST;
      doneFlag        <= 1'b0;
      skipPending     <= 1'b0;
      lastInstr       <= 8'h00;
      convStart       <= 1'b0;
      compStart       <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      acc             <= next_acc;
      carry           <= next_carry;
      ctrl            <= next_ctrl;
      doneFlag        <= next_doneFlag;
      skipPending     <= next_skipPending;
      lastInstr       <= next_lastInstr;
      convStart       <= next_convStart;
      compStart       <= next_compStart;
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
    end
  end

  aic_irq #(
    .N (AIC_EVT_N)
  ) u_irq (
    .mclk    (mclk),
    .resetn  (resetn),
    .evt     (evt),
    .clrWe   (wr_hit(wrEn, avs_address, OFF_IRQ_CLR)),
    .clrData (avs_writedata[AIC_EVT_N-1:0]),
    .enWe    (wr_hit(wrEn, avs_address, OFF_IRQ_EN)),
    .enData  (avs_writedata[AIC_EVT_N-1:0]),
    .status  (irqStatus),
    .enable  (irqEnable),
    .irq     (irq)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  chk_add_result: assert property (
    execAdd |=> acc == $past(addSum))
    else $error("accumulator does not hold the sum");

  chk_carry_hold: assert property (
    execAdd |=> carry == $past(carry))
    else $error("carry changed by add-immediate");

  chk_ovf_skip: assert property (
    execAdd |=> skipPending == $past(addOvf))
    else $error("skip does not follow overflow");

  chk_start_clears: assert property (
    execStart && !convDone |=> !doneFlag)
    else $error("done flag not cleared by convert-start");

  chk_conv_launch: assert property (
    execStart && !ctrl[3] |=> convStart && !compStart ##1 !convStart)
    else $error("conversion not launched as one pulse");

  chk_comp_launch: assert property (
    execStart && ctrl[3] |=> compStart && !convStart)
    else $error("comparator not launched");

  chk_select_bit: assert property (
    compStart |-> $past(ctrl[3]))
    else $error("comparator start without select bit");

  chk_test_skip: assert property (
    execTest && doneFlag && !convDone |=> skipPending && !doneFlag)
    else $error("done test did not skip and clear");

  chk_skip_suppress: assert property (
    instrTake && skipPending |=>
      !skipPending && !convStart && !compStart && acc == $past(acc))
    else $error("skipped word was executed");

  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not released after one cycle");

  chk_carry_bus: assert property (
    !wr_hit(wrEn, avs_address, OFF_CARRY) |=> carry == $past(carry))
    else $error("carry changed without a bus write");

  chk_ovf_event: assert property (
    execAdd && addOvf |=> irqStatus[EVT_OVF_BIT])
    else $error("overflow event not recorded");

  chk_start_excl: assert property (
    !(convStart && compStart))
    else $error("conversion and comparator started together");

  chk_conv_cause: assert property (
    convStart |-> $past(execStart) && !$past(ctrl[CTRL_COMP_BIT]))
    else $error("conversion start without convert-start");

  chk_comp_pulse: assert property (
    compStart |=> !compStart)
    else $error("comparator start longer than one cycle");

  chk_comp_cause: assert property (
    compStart |-> $past(execStart))
    else $error("comparator start without convert-start");

  chk_test_idle: assert property (
    execTest && !doneFlag |=> !skipPending)
    else $error("done test skipped with flag clear");

  chk_skip_event: assert property (
    instrTake && skipPending |=> irqStatus[EVT_SKIP_BIT])
    else $error("skipped word not recorded");

  chk_done_set: assert property (
    convDone |=> doneFlag)
    else $error("completion did not set the done flag");

  chk_irq_level: assert property (
    irq == |(irqStatus & irqEnable))
    else $error("interrupt level disagrees with status");

  chk_ack_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  cov_ovf_skip: cover property (execAdd && addOvf ##[1:20] instrTake);
  cov_comp_run: cover property (execStart && ctrl[3]);
  cov_test_hit: cover property (execTest && doneFlag);
  cov_irq_up:   cover property ($rose(irq));
  cov_skip_hit: cover property (instrTake && skipPending);

endmodule // aic_exec

/* aic_conv_model.sv */
`timescale 1ns/1ps
module aic_conv_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       convStart,
  input  wire logic       compStart,
  input  wire logic [7:0] latency,
  output logic            convDone
);
  logic [7:0] left;
  logic       busy;
  // A start while busy restarts the count, as a real converter would
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      left     <= 8'h00;
      busy     <= 1'b0;
      convDone <= 1'b0;
    end else begin
      convDone <= busy && left == 8'h00;
      if (convStart || compStart) begin
        busy <= 1'b1;
        left <= latency;
      end else if (busy && left == 8'h00) begin
        busy <= 1'b0;
      end else if (busy) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule // aic_conv_model

/* add_immediate_and_convert_start_test.sv */
`timescale 1ns/1ps
module add_immediate_and_convert_start_test;
  import aic_pkg::*;
  logic                  mclk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [AIC_ADDR_W-1:0] avs_address;
  logic [31:0]           avs_writedata, avs_readdata, q;
  logic [3:0]            avs_byteenable, ctl;
  logic                  convDone, convStart, compStart, irq;
  logic [7:0]            latency;
  logic [4:0]            s;
  int                    fail_count, tests_run, nConv, nComp, a, b, c;

  aic_exec dut (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .convDone(convDone), .convStart(convStart), .compStart(compStart),
    .irq(irq));
  aic_conv_model conv (.mclk(mclk), .resetn(resetn), .convStart(convStart),
    .compStart(compStart), .latency(latency), .convDone(convDone));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (convStart === 1'b1) nConv++;
    if (compStart === 1'b1) nComp++;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Expected 4-bit add-immediate result with its carry out in bit 4
  function automatic logic [4:0] exp_add(input int x, input int y);
    return 5'(x + y);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Entered just after an edge; leaves one idle edge so no signal is
  // assigned twice in a time step
  task automatic bus(input logic wr, input logic [4:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      stop_test();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [4:0] ad, input logic [31:0] e,
                    input string nm);
    bus(1'b0, ad, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (q[STAT_DONE_BIT] !== 1'b1 && n < 60);
    if (q[STAT_DONE_BIT] !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask

  initial begin
    logic [4:0] offs [6];
    offs = '{OFF_ACC, OFF_CARRY, OFF_CTRL, OFF_STATUS, OFF_IRQ_STAT,
             OFF_IRQ_EN};
    resetn = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    latency = 8'h1e;
    fail_count = 0;
    tests_run = 0;
    nConv = 0;
    nComp = 0;
    a = $urandom(32'h5780);
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk("irq reset", irq, 0);
    for (int i = 0; i < 6; i++) rd(offs[i], 0, "reset value");
    bus(1'b1, OFF_IRQ_EN, 32'h7);
    // First two cases sit on either side of the overflow boundary
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 15 : (i == 1) ? 14 : $urandom % 16;
      b = (i < 2) ? 1 : $urandom % 16;
      c = $urandom % 2;
      s = exp_add(a, b);
      bus(1'b1, OFF_ACC, a);
      bus(1'b1, OFF_CARRY, c);
      bus(1'b1, OFF_INSTR, {24'h0, 4'h1, 4'(b)});
      rd(OFF_ACC, s[3:0], "acc sum");
      rd(OFF_CARRY, c, "carry kept");
      rd(OFF_STATUS, {s[4], 1'b0}, "skip armed");
      chk("irq overflow", irq, s[4]);
      bus(1'b1, OFF_INSTR, 32'h45);
      rd(OFF_ACC, s[4] ? s[3:0] : 4'h5, "next instr");
      rd(OFF_IRQ_STAT, {s[4], s[4], 1'b0}, "irq events");
      if (i == 0) begin
        bus(1'b1, OFF_IRQ_EN, 32'h0);
        chk("irq masked", irq, 0);
        bus(1'b1, OFF_IRQ_EN, 32'h7);
        chk("irq unmasked", irq, 1);
      end
      bus(1'b1, OFF_IRQ_CLR, 32'h7);
      chk("irq cleared", irq, 0);
    end
    for (int m = 0; m < 2; m++) begin
      ctl = {m[0], 3'($urandom)};
      bus(1'b1, OFF_CTRL, ctl);
      a = nConv;
      b = nComp;
      bus(1'b1, OFF_INSTR, 32'h20);
      rd(OFF_CTRL, ctl, "ctrl kept");
      chk("conv pulses", nConv - a, m == 0);
      chk("comp pulses", nComp - b, m == 1);
      wait_done();
      rd(OFF_IRQ_STAT, 32'h1, "done event");
      bus(1'b1, OFF_INSTR, 32'h2a);
      rd(OFF_STATUS, 32'h0, "done cleared");
      wait_done();
      bus(1'b1, OFF_INSTR, 32'h30);
      rd(OFF_STATUS, 32'h2, "done test");
      a = nConv + nComp;
      bus(1'b1, OFF_INSTR, 32'h20);
      chk("start skipped", nConv + nComp - a, 0);
      rd(OFF_STATUS, 32'h0, "skip spent");
      bus(1'b1, OFF_INSTR, 32'h30);
      rd(OFF_STATUS, 32'h0, "done test idle");
      bus(1'b1, OFF_IRQ_CLR, 32'h7);
    end
    // Refused write and idle opcodes leave the accumulator alone
    bus(1'b1, OFF_ACC, 32'h9);
    avs_byteenable <= 4'he;
    bus(1'b1, OFF_ACC, 32'h3);
    avs_byteenable <= 4'hf;
    bus(1'b1, OFF_INSTR, 32'h0f);
    bus(1'b1, OFF_INSTR, 32'h5c);
    rd(OFF_ACC, 32'h9, "acc kept");
    rd(OFF_INSTR, 32'h5c, "last instr");
    stop_test();
  end
endmodule // add_immediate_and_convert_start_test
